/* File: common/vic_pkg.sv */
// shared constants and types for the vectored interrupt controller
package vic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_REQ = 8;  // request inputs
  localparam int NUM_W = 3;  // width of a request number
  localparam int PIN_W = 25;  // pins passing the input synchroniser

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;  // all requests enabled
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DOUT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LOW_MSB = 7;  // programmed low vector bits 7..4
  localparam int CTRL_LOW_LSB = 4;
  localparam int CTRL_INTV_LSB = 0;  // interval select, two bits
  localparam int CTRL_MASK_RST = 2;  // write 1: clear mask register
  localparam int CTRL_INT_RST = 3;  // write 1: clear pending status

  // interval select codes
  localparam logic [1:0] INTV_2 = 2'h0;
  localparam logic [1:0] INTV_4 = 2'h1;
  localparam logic [1:0] INTV_8 = 2'h2;
  localparam logic [1:0] INTV_16 = 2'h3;

  // ----------------------------------------------------------------
  // bus codes and fixed bytes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_VEC_PAGE = 2'h2;  // x=1 y=0
  localparam logic [1:0] SEL_CTRL_POLL = 2'h1;  // x=0 y=1
  localparam logic [1:0] SEL_STAT_MASK = 2'h0;  // x=0 y=0
  localparam logic [1:0] SEL_UNUSED = 2'h3;  // x=1 y=1
  localparam logic [7:0] LONG_BRANCH_OP = 8'hc0;  // long-branch opcode
  localparam int POLL_ANY_BIT = 7;  // poll: an unmasked request is pending

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // which byte of the three-byte vector fetch comes next
  typedef enum logic [2:0] {
    VB_OPCODE = 3'h1,
    VB_PAGE = 3'h2,
    VB_LOW = 3'h4
  } vec_byte_t;

  // chip selects as seen at the address strobe
  typedef struct packed {
    logic cs;
    logic cs_n;
    logic sel_x;
    logic sel_y;
  } chip_sel_t;

  // direction strobes, both active low
  typedef struct packed {
    logic rd_n;
    logic wr_n;
  } access_t;

endpackage : vic_pkg

/* File: logic/req_priority.sv */
// highest-priority unmasked pending request finder
`timescale 1ns/1ps
module req_priority (
  // pending and mask
  input wire logic [7:0] pend,
  input wire logic [7:0] mask,
  // result
  output logic any,
  output logic [2:0] num
);

  // ----------------------------------------------------------------
  // scan upward so the highest index wins
  // ----------------------------------------------------------------
  always_comb begin
    any = 1'b0;
    num = 3'h0;
    for (int i = 0; i < vic_pkg::NUM_REQ; i++) begin
      // masked inputs never take part
      if (pend[i] && !mask[i]) begin
        any = 1'b1;
        num = i[2:0];
      end
    end
  end

endmodule : req_priority

/* File: logic/vector_irq_unit.sv */
// vectored interrupt controller on a strobed 8-bit processor bus
`timescale 1ns/1ps
module vector_irq_unit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus strobes and selects (asynchronous pins)
  input wire logic address_phase_strobe,
  input wire logic data_phase_strobe,
  input wire logic chip_select,
  input wire logic chip_select_n,
  input wire logic mux_select_x,
  input wire logic mux_select_y,
  input wire logic rd_n,
  input wire logic wr_n,
  // data bus, split into three signals
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // requests and priority chain
  input wire logic [7:0] request_input,
  input wire logic chain_in,
  output logic chain_out,
  // interrupt to the processor
  output logic irq_n
);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic [24:0] pins_w;  // raw pins
  logic [24:0] sync1_r;  // first stage, read only by sync2_r
  logic [24:0] sync2_r;  // safe copy

  assign pins_w = {address_phase_strobe, data_phase_strobe,
                   chip_select, chip_select_n, mux_select_x,
                   mux_select_y, rd_n, wr_n, data_in, request_input,
                   chain_in};

  // two flops before anything looks at a pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 25'h0000000;
      sync2_r <= 25'h0000000;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // unpacked synchronised pins
  // ----------------------------------------------------------------
  logic tpa_s;  // address strobe
  logic tpb_s;  // data strobe
  vic_pkg::chip_sel_t csel_s;  // selects
  vic_pkg::access_t acc_s;  // direction
  logic [7:0] din_s;  // data bus
  logic [7:0] req_s;  // requests
  logic chain_s;  // higher controller grants us

  assign tpa_s = sync2_r[24];
  assign tpb_s = sync2_r[23];
  assign csel_s = sync2_r[22:19];
  assign acc_s = sync2_r[18:17];
  assign din_s = sync2_r[16:9];
  assign req_s = sync2_r[8:1];
  assign chain_s = sync2_r[0];

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic tpa_d_r, tpa_d_nxt;  // strobe history for edges
  logic tpb_d_r, tpb_d_nxt;
  logic [7:0] req_d_r, req_d_nxt;  // request history
  logic sel_r, sel_nxt;  // chip selected for this cycle
  logic [7:0] page_r, page_nxt;  // vector page
  logic [7:0] ctrl_r, ctrl_nxt;  // low bits and interval
  logic [7:0] mask_r, mask_nxt;  // 1 masks a request
  logic [7:0] pend_r, pend_nxt;  // status: latched requests
  vic_pkg::vec_byte_t vb_r, vb_nxt;  // next vector byte
  logic [2:0] svc_r, svc_nxt;  // request being serviced
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic irq_n_r, irq_n_nxt;
  logic chain_out_r, chain_out_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic any_w;  // unmasked request pending
  logic [2:0] num_w;  // its number
  logic [7:0] low_w;  // low vector byte for svc_r
  logic [1:0] code_w;  // register code during data strobe
  logic tpa_rise_w, tpa_fall_w, tpb_rise_w, tpb_fall_w;
  logic is_rd_w, is_wr_w;
  logic respond_w;  // allowed to answer a vector fetch
  logic vec_rd_w;  // vector byte read taken this cycle

  req_priority u_prio (
    .pend(pend_r),
    .mask(mask_r),
    .any(any_w),
    .num(num_w)
  );

  vector_low_gen u_low (
    .ctrl(ctrl_r),
    .num(svc_r),
    .low(low_w)
  );

  assign tpa_rise_w = tpa_s && !tpa_d_r;
  assign tpa_fall_w = !tpa_s && tpa_d_r;
  assign tpb_rise_w = tpb_s && !tpb_d_r;
  assign tpb_fall_w = !tpb_s && tpb_d_r;
  assign code_w = {csel_s.sel_x, csel_s.sel_y};
  assign is_rd_w = !acc_s.rd_n && acc_s.wr_n;
  assign is_wr_w = acc_s.rd_n && !acc_s.wr_n;
  // a fetch already in progress keeps its controller even if a
  // higher request arrives, so the three bytes stay consistent
  assign respond_w = (vb_r != vic_pkg::VB_OPCODE) ||
                     (any_w && chain_s);
  assign vec_rd_w = tpb_rise_w && sel_r && is_rd_w &&
                    (code_w == vic_pkg::SEL_VEC_PAGE) && respond_w;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] clr;
    clr = 8'h00;
    tpa_d_nxt = tpa_s;
    tpb_d_nxt = tpb_s;
    req_d_nxt = req_s;
    sel_nxt = sel_r;
    page_nxt = page_r;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    vb_nxt = vb_r;
    svc_nxt = svc_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    // a new address strobe or read released ends any drive
    if (tpa_rise_w || acc_s.rd_n) begin
      oe_nxt = 1'b0;
    end
    // selects are caught on the trailing edge of the address strobe
    if (tpa_fall_w) begin
      sel_nxt = csel_s.cs && !csel_s.cs_n &&
                csel_s.sel_x && csel_s.sel_y;
    end
    // reads start on the rising data strobe
    if (tpb_rise_w && sel_r && is_rd_w) begin
      case (code_w)
        vic_pkg::SEL_VEC_PAGE: begin
          if (respond_w) begin
            oe_nxt = 1'b1;
            case (vb_r)
              vic_pkg::VB_OPCODE: begin
                dout_nxt = vic_pkg::LONG_BRANCH_OP;
                svc_nxt = num_w;
                vb_nxt = vic_pkg::VB_PAGE;
              end
              vic_pkg::VB_PAGE: begin
                dout_nxt = page_r;
                vb_nxt = vic_pkg::VB_LOW;
              end
              vic_pkg::VB_LOW: begin
                dout_nxt = low_w;
                clr[svc_r] = 1'b1;  // serviced request retires
                vb_nxt = vic_pkg::VB_OPCODE;
              end
              default: begin
                vb_nxt = vic_pkg::VB_OPCODE;
              end
            endcase
          end
        end
        vic_pkg::SEL_STAT_MASK: begin
          oe_nxt = 1'b1;
          dout_nxt = pend_r;
        end
        vic_pkg::SEL_CTRL_POLL: begin
          oe_nxt = 1'b1;
          dout_nxt = {any_w, 4'h0, num_w};
        end
        default: begin
          oe_nxt = 1'b0;  // both selects high: unused
        end
      endcase
    end
    // writes take the data on the trailing data strobe
    if (tpb_fall_w && sel_r && is_wr_w) begin
      case (code_w)
        vic_pkg::SEL_VEC_PAGE: begin
          page_nxt = din_s;
        end
        vic_pkg::SEL_CTRL_POLL: begin
          ctrl_nxt = din_s;
          if (din_s[vic_pkg::CTRL_INT_RST]) begin
            clr = 8'hff;  // master interrupt reset
            vb_nxt = vic_pkg::VB_OPCODE;
          end
          if (din_s[vic_pkg::CTRL_MASK_RST]) begin
            mask_nxt = vic_pkg::MASK_RESET;  // master mask reset
          end
        end
        vic_pkg::SEL_STAT_MASK: begin
          mask_nxt = din_s;
        end
        default: begin
          page_nxt = page_r;
        end
      endcase
    end
    if (tpb_fall_w) begin
      sel_nxt = 1'b0;
    end
    // a new request edge wins over a clear in the same cycle
    pend_nxt = (pend_r & ~clr) | (req_s & ~req_d_r);
    irq_n_nxt = !any_w;
    chain_out_nxt = chain_s && !any_w;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tpa_d_r <= 1'b0;
      tpb_d_r <= 1'b0;
      req_d_r <= 8'h00;
      sel_r <= 1'b0;
      page_r <= vic_pkg::PAGE_RESET;
      ctrl_r <= vic_pkg::CTRL_RESET;
      mask_r <= vic_pkg::MASK_RESET;
      pend_r <= vic_pkg::STATUS_RESET;
      vb_r <= vic_pkg::VB_OPCODE;
      svc_r <= 3'h0;
      dout_r <= vic_pkg::DOUT_RESET;
      oe_r <= 1'b0;
      irq_n_r <= 1'b1;
      chain_out_r <= 1'b0;
    end else begin
      tpa_d_r <= tpa_d_nxt;
      tpb_d_r <= tpb_d_nxt;
      req_d_r <= req_d_nxt;
      sel_r <= sel_nxt;
      page_r <= page_nxt;
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      pend_r <= pend_nxt;
      vb_r <= vb_nxt;
      svc_r <= svc_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      irq_n_r <= irq_n_nxt;
      chain_out_r <= chain_out_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe = oe_r;
  assign irq_n = irq_n_r;
  assign chain_out = chain_out_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_vec_opcode;
    vec_rd_w && vb_r == vic_pkg::VB_OPCODE;
  endsequence
  sequence s_vec_page;
    vec_rd_w && vb_r == vic_pkg::VB_PAGE;
  endsequence
  sequence s_vec_low;
    vec_rd_w && vb_r == vic_pkg::VB_LOW;
  endsequence

  a_opcode_first: assert property (s_vec_opcode |=>
    data_oe && data_out == vic_pkg::LONG_BRANCH_OP &&
    vb_r == vic_pkg::VB_PAGE)
    else $error("vector fetch did not open with the opcode");
  a_page_byte: assert property (s_vec_page |=>
    data_out == $past(page_r) && vb_r == vic_pkg::VB_LOW)
    else $error("second vector byte is not the page");
  a_low_byte: assert property (s_vec_low |=>
    data_out == $past(low_w) && vb_r == vic_pkg::VB_OPCODE)
    else $error("third vector byte is wrong");
  a_low_top_bit: assert property (
    low_w[7] == ctrl_r[7] && low_w[3:0] ==
    4'({1'b0, svc_r} << (3'(ctrl_r[1:0]) + 3'h1)))
    else $error("low vector byte bits out of place");
  a_masked_skip: assert property (any_w |->
    pend_r[num_w] && !mask_r[num_w] && !(|(pend_r & ~mask_r &
    ~(8'hff >> (3'h7 - num_w)))))
    else $error("priority picked a masked or lower request");
  a_only_chosen: assert property (
    tpb_rise_w && sel_r && is_rd_w && !respond_w &&
    code_w == vic_pkg::SEL_VEC_PAGE && !tpa_rise_w |=> !data_oe)
    else $error("unselected controller drove a vector");
  a_status_read: assert property (
    tpb_rise_w && sel_r && is_rd_w &&
    code_w == vic_pkg::SEL_STAT_MASK |=>
    data_oe && data_out == $past(pend_r))
    else $error("status read returned wrong data");
  a_page_write: assert property (
    tpb_fall_w && sel_r && is_wr_w &&
    code_w == vic_pkg::SEL_VEC_PAGE |=> page_r == $past(din_s))
    else $error("page write not stored");
  a_unused_code: assert property (
    tpb_fall_w && sel_r && code_w == vic_pkg::SEL_UNUSED |=>
    $stable(page_r) && $stable(ctrl_r) && $stable(mask_r))
    else $error("unused select code changed a register");
  a_select_latch: assert property (
    tpa_fall_w && !(csel_s.sel_x && csel_s.sel_y) |=> !sel_r)
    else $error("selected without both selects high");

endmodule : vector_irq_unit

/* File: logic/vector_low_gen.sv */
// builds the low byte of an issued vector
`timescale 1ns/1ps
module vector_low_gen (
  // programmed control byte
  input wire logic [7:0] ctrl,
  // request being serviced
  input wire logic [2:0] num,
  // low vector byte
  output logic [7:0] low
);

  // ----------------------------------------------------------------
  // programmed upper bits plus number times interval
  // ----------------------------------------------------------------
  function automatic logic [7:0] vec_low(input logic [7:0] c,
                                         input logic [2:0] n);
    logic [7:0] keep;
    logic [7:0] nb;
    keep = 8'h00;
    nb = {5'h00, n};
    case (c[vic_pkg::CTRL_INTV_LSB +: 2])
      vic_pkg::INTV_2: begin
        keep = 8'hf0;
        nb = nb << 1;
      end
      vic_pkg::INTV_4: begin
        keep = 8'he0;
        nb = nb << 2;
      end
      vic_pkg::INTV_8: begin
        keep = 8'hc0;
        nb = nb << 3;
      end
      default: begin
        keep = 8'h80;
        nb = nb << 4;
      end
    endcase
    // bits not kept from control come from the request, rest zero
    vec_low = (c & keep) | nb;
  endfunction : vec_low

  assign low = vec_low(ctrl, num);

endmodule : vector_low_gen

/* File: verif/bus_master_model.sv */
// processor-side bus model: strobed accesses toward the controller
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input wire logic sys_clk,
  // strobes and selects toward the controller
  output logic address_phase_strobe,
  output logic data_phase_strobe,
  output logic chip_select,
  output logic chip_select_n,
  output logic mux_select_x,
  output logic mux_select_y,
  output logic rd_n,
  output logic wr_n,
  // data bus halves
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  // ----------------------------------------------------------------
  // idle bus
  // ----------------------------------------------------------------
  // low turns the plain selects inactive, so accesses must be refused
  logic cs_ok = 1'b1;

  // deselected, muxed selects parked high, data pattern arbitrary
  initial begin
    address_phase_strobe = 1'b0;
    data_phase_strobe = 1'b0;
    chip_select = 1'b0;
    chip_select_n = 1'b1;
    {mux_select_x, mux_select_y} = 2'h3;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h3c;
  end

  // wait a number of rising edges
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // ----------------------------------------------------------------
  // one access: address strobe, then data strobe
  // ----------------------------------------------------------------
  // strobes held 3+ clocks so the two-flop pin sync sees each level
  task automatic access(input logic [1:0] sel, input logic wr,
                        input logic [7:0] wdata, output logic [7:0] rdata,
                        output logic oe);
    @(posedge sys_clk);
    address_phase_strobe <= 1'b1;
    chip_select <= cs_ok; // memory-mapped select, no port space
    chip_select_n <= !cs_ok;
    {mux_select_x, mux_select_y} <= 2'h3; // both high at strobe
    cyc(3);
    address_phase_strobe <= 1'b0; // selects valid at trailing edge
    cyc(3);
    {mux_select_x, mux_select_y} <= sel; // register code for data
    rd_n <= wr;
    wr_n <= !wr;
    data_in <= wdata;
    cyc(1);
    data_phase_strobe <= 1'b1;
    cyc(6);
    // answer stands while the data strobe is high
    rdata = data_out;
    oe = data_oe;
    data_phase_strobe <= 1'b0;
    cyc(3);
    // released bus shows the inverse, never the stale byte
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~wdata;
    chip_select <= 1'b0;
    chip_select_n <= 1'b1;
    {mux_select_x, mux_select_y} <= 2'h3;
    cyc(5);
  endtask : access
endmodule : bus_master_model

/* File: verif/vector_irq_unit_bench.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vector_irq_unit_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0; // 50 MHz
  logic rst = 1'b1; // synchronous, active high
  logic [7:0] request_input = 8'h00;
  logic chain_in = 1'b1; // top of chain by default
  logic as_w, ds_w, cs_w, cs_n_w, x_w, y_w, rd_n_w, wr_n_w;
  logic [7:0] din_w, data_out;
  logic data_oe, chain_out, irq_n;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] keep_v, low_v;

  always #10 sys_clk = ~sys_clk;

  // processor side
  bus_master_model m (.sys_clk(sys_clk), .address_phase_strobe(as_w),
    .data_phase_strobe(ds_w), .chip_select(cs_w), .chip_select_n(cs_n_w),
    .mux_select_x(x_w), .mux_select_y(y_w), .rd_n(rd_n_w), .wr_n(wr_n_w),
    .data_in(din_w), .data_out(data_out), .data_oe(data_oe));

  vector_irq_unit DUT (.sys_clk(sys_clk), .rst(rst),
    .address_phase_strobe(as_w), .data_phase_strobe(ds_w),
    .chip_select(cs_w), .chip_select_n(cs_n_w), .mux_select_x(x_w),
    .mux_select_y(y_w), .rd_n(rd_n_w), .wr_n(wr_n_w), .data_in(din_w),
    .data_out(data_out), .data_oe(data_oe), .request_input(request_input),
    .chain_in(chain_in), .chain_out(chain_out), .irq_n(irq_n));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check1

  // single verdict point for the main sequence and the watchdog
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // bus and request helpers
  // ----------------------------------------------------------------
  // read expecting the device to drive the given byte
  task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    m.access(sel, 1'b0, 8'h00, d, oe);
    check1(oe, 1'b1);
    check8(d, exp);
  endtask : rd_chk

  // read that must leave the bus undriven
  task automatic rd_none(input logic [1:0] sel);
    logic [7:0] d;
    logic oe;
    m.access(sel, 1'b0, 8'h00, d, oe);
    check1(oe, 1'b0);
  endtask : rd_none

  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    logic [7:0] d;
    logic oe;
    m.access(sel, 1'b1, v, d, oe);
  endtask : wr

  // one rising edge on a request; requests are edge-latched
  task automatic pulse(input int k);
    @(posedge sys_clk);
    request_input[k] <= 1'b1;
    m.cyc(4);
    request_input[k] <= 1'b0;
    m.cyc(4);
  endtask : pulse

  // full three-byte vector fetch
  task automatic vec_chk(input logic [7:0] low);
    rd_chk(vic_pkg::SEL_VEC_PAGE, vic_pkg::LONG_BRANCH_OP);
    rd_chk(vic_pkg::SEL_VEC_PAGE, 8'h5a);
    rd_chk(vic_pkg::SEL_VEC_PAGE, low);
  endtask : vec_chk

  // ----------------------------------------------------------------
  // watchdog: whole sequence needs about 1200 clocks
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    m.cyc(4);
    rst <= 1'b0;
    m.cyc(3);
    check1(data_oe, 1'b0);
    check1(irq_n, 1'b1);
    rd_chk(vic_pkg::SEL_STAT_MASK, 8'h00);
    rd_chk(vic_pkg::SEL_CTRL_POLL, 8'h00);
    rd_none(vic_pkg::SEL_VEC_PAGE); // nothing pending
    wr(vic_pkg::SEL_VEC_PAGE, 8'h5a);
    // deselected accesses are refused: no drive, page keeps 5a
    m.cs_ok = 1'b0;
    rd_none(vic_pkg::SEL_STAT_MASK);
    wr(vic_pkg::SEL_VEC_PAGE, 8'ha5);
    m.cs_ok = 1'b1;
    // every interval; odd request numbers so each fetch names one
    for (int i = 0; i < 4; i++) begin
      wr(vic_pkg::SEL_CTRL_POLL, 8'hb0 | 8'(i));
      pulse(2 * i + 1);
      check1(irq_n, 1'b0);
      check1(chain_out, 1'b0);
      rd_chk(vic_pkg::SEL_STAT_MASK, 8'h01 << (2 * i + 1));
      rd_chk(vic_pkg::SEL_CTRL_POLL, 8'h80 | 8'(2 * i + 1));
      keep_v = 8'hf0 << i;
      low_v = (keep_v & 8'hb0) | (8'(2 * i + 1) << (i + 1));
      vec_chk(low_v);
      rd_chk(vic_pkg::SEL_STAT_MASK, 8'h00);
      check1(irq_n, 1'b1);
    end
    // masked top request stays in status but is passed over
    wr(vic_pkg::SEL_STAT_MASK, 8'h80);
    pulse(7);
    check1(irq_n, 1'b1);
    pulse(1);
    rd_chk(vic_pkg::SEL_STAT_MASK, 8'h82);
    rd_chk(vic_pkg::SEL_CTRL_POLL, 8'h81);
    vec_chk(8'h90);
    // master mask reset frees request 7
    wr(vic_pkg::SEL_CTRL_POLL, 8'hb7);
    rd_chk(vic_pkg::SEL_CTRL_POLL, 8'h87);
    check1(irq_n, 1'b0);
    // a lower controller in the chain must not answer
    @(posedge sys_clk);
    chain_in <= 1'b0;
    m.cyc(4);
    check1(chain_out, 1'b0);
    rd_none(vic_pkg::SEL_VEC_PAGE);
    @(posedge sys_clk);
    chain_in <= 1'b1;
    m.cyc(4);
    // master interrupt reset empties status
    wr(vic_pkg::SEL_CTRL_POLL, 8'hbb);
    rd_chk(vic_pkg::SEL_STAT_MASK, 8'h00);
    check1(irq_n, 1'b1);
    check1(chain_out, 1'b1);
    // a write with both selects high must leave page and mask alone
    wr(vic_pkg::SEL_UNUSED, 8'hff);
    pulse(3);
    vec_chk(8'hb0);
    rd_none(vic_pkg::SEL_UNUSED);
    rd_none(vic_pkg::SEL_VEC_PAGE);
    finish_test();
  end
endmodule : vector_irq_unit_bench
